// file: rtl/psc_checker.sv
// Receiving private section checker: header parse, trailer check, payload out
`timescale 1ns/100ps
// How it works
// - Syntax one: trailer must be correct CRC
// - Syntax zero: trailer must be all ones
// - Sender sets private bit inverse of syntax
// - Syntax zero: check private one, trailer ones
// - Syntax one: check private zero, CRC good
// - Same header layout for both syntax values
// - Length counts bytes after it, trailer included
// - Table id selects payload kind
// - Extension field carried, never interpreted
module psc_checker #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] sec_data,
  input wire logic sec_valid,
  input wire logic sec_start,
  output logic sec_ready,
  output psc_pkg::psc_beat_t pay_beat,
  output logic pay_valid,
  input wire logic pay_ready,
  output psc_pkg::psc_verdict_t verdict,
  output logic verdict_valid
);
  import psc_pkg::*;

  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("psc_checker needs a FIFO of at least two words");
  end

  typedef enum logic [1:0] {
    PSC_ST_IDLE = 2'b00,
    PSC_ST_HDR = 2'b01,
    PSC_ST_BODY = 2'b10
  } psc_state_t;

  psc_state_t state_r, state_nxt;
  logic [2:0] hidx_r, hidx_nxt;
  logic [11:0] left_r, left_nxt;
  logic [31:0] crc_r, crc_nxt;
  logic [31:0] tail_r, tail_nxt;
  logic [31:0] crc_pay_r, crc_pay_nxt;
  psc_verdict_t vd_r, vd_nxt;
  logic vdv_r, vdv_nxt;
  logic first_r, first_nxt;
  psc_kind_t kind_r, kind_nxt;
  logic fifo_in_ready;
  psc_beat_t beat;
  logic beat_valid;
  logic take;

  // Bytewise CRC over the section, MSB first
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      if (r[31] ^ d[i]) begin
        r = {r[30:0], 1'b0} ^ PSC_CRC_POLY;
      end else begin
        r = {r[30:0], 1'b0};
      end
    end
    return r;
  endfunction : crc_byte

  // Input stalls only in the body, trailer bytes included, while the FIFO cannot take a byte
  assign sec_ready = (state_r != PSC_ST_BODY) || fifo_in_ready;
  assign take = sec_valid && sec_ready;

  always_comb begin
    state_nxt = state_r;
    hidx_nxt = hidx_r;
    left_nxt = left_r;
    crc_nxt = crc_r;
    tail_nxt = tail_r;
    crc_pay_nxt = crc_pay_r;
    vd_nxt = vd_r;
    vdv_nxt = 1'b0;
    first_nxt = first_r;
    kind_nxt = kind_r;
    beat = '0;
    beat_valid = 1'b0;
    if (take && sec_start) begin
      // A start marker always restarts parsing; a cut-off section gives no verdict
      state_nxt = PSC_ST_HDR;
      hidx_nxt = PSC_IDX_FLAGS;
      crc_nxt = crc_byte(PSC_CRC_INIT, sec_data);
      vd_nxt = '0;
      vd_nxt.table_id = sec_data;
      unique case (sec_data)
        PSC_TID_MPE: kind_nxt = PSC_KIND_MPE;
        PSC_TID_MSG: kind_nxt = PSC_KIND_MSG;
        PSC_TID_DESC: kind_nxt = PSC_KIND_DESC;
        default: kind_nxt = PSC_KIND_OTHER;
      endcase
    end else if (take) begin
      unique case (state_r)
        PSC_ST_IDLE: begin
        end
        PSC_ST_HDR: begin
          crc_nxt = crc_byte(crc_r, sec_data);
          hidx_nxt = hidx_r + 3'h1;
          left_nxt = left_r - 12'h001;
          unique case (hidx_r)
            PSC_IDX_FLAGS: begin
              vd_nxt.syntax = sec_data[PSC_BIT_SYNTAX];
              vd_nxt.err_priv = sec_data[PSC_BIT_PRIV] == sec_data[PSC_BIT_SYNTAX];
              left_nxt = {sec_data[PSC_LEN_HI_MSB:0], 8'h00};
            end
            PSC_IDX_LEN_LO: begin
              left_nxt = {left_r[11:8], sec_data};
              vd_nxt.length = {left_r[11:8], sec_data};
            end
            PSC_IDX_EXT_HI, PSC_IDX_EXT_LO: begin
              // Extension is reserved: checked by CRC only, not decoded
            end
            PSC_IDX_VER: begin
              vd_nxt.version = sec_data[PSC_VER_MSB:PSC_VER_LSB];
              vd_nxt.current_next = sec_data[PSC_BIT_CN];
            end
            PSC_IDX_SECNUM: vd_nxt.section_number = sec_data;
            PSC_IDX_LAST: begin
              vd_nxt.last_section_number = sec_data;
              if (vd_r.length < PSC_LEN_MIN) begin
                // Too short to hold the fixed header tail and a trailer
                vd_nxt.err_length = 1'b1;
                vdv_nxt = 1'b1;
                state_nxt = PSC_ST_IDLE;
              end else begin
                state_nxt = PSC_ST_BODY;
                first_nxt = 1'b1;
                tail_nxt = '0;
                crc_pay_nxt = crc_byte(crc_r, sec_data);
              end
            end
            default: begin
            end
          endcase
        end
        PSC_ST_BODY: begin
          // Every byte shifts into a 4-byte trailer register; bytes before the last four go straight out as payload
          left_nxt = left_r - 12'h001;
          tail_nxt = {tail_r[23:0], sec_data};
          if (left_r <= 12'(PSC_TRL_BYTES)) begin
            // Trailer bytes: CRC stays frozen at header+payload
          end else begin
            crc_pay_nxt = crc_byte(crc_pay_r, sec_data);
            beat.data = sec_data;
            beat.first = first_r;
            beat.last = left_r == 12'(PSC_TRL_BYTES + 1);
            beat.kind = kind_r;
            beat_valid = 1'b1;
            first_nxt = 1'b0;
          end
          if (left_r == 12'h001) begin
            state_nxt = PSC_ST_IDLE;
            vdv_nxt = 1'b1;
            if (vd_r.syntax) begin
              vd_nxt.err_trailer = {tail_r[23:0], sec_data} != crc_pay_r;
            end else begin
              vd_nxt.err_trailer = {tail_r[23:0], sec_data} != PSC_NO_CRC;
            end
          end
        end
        default: state_nxt = PSC_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_r <= PSC_ST_IDLE;
      hidx_r <= '0;
      left_r <= '0;
      crc_r <= PSC_CRC_INIT;
      tail_r <= '0;
      crc_pay_r <= PSC_CRC_INIT;
      vd_r <= '0;
      vdv_r <= 1'b0;
      first_r <= 1'b0;
      kind_r <= PSC_KIND_OTHER;
    end else begin
      state_r <= state_nxt;
      hidx_r <= hidx_nxt;
      left_r <= left_nxt;
      crc_r <= crc_nxt;
      tail_r <= tail_nxt;
      crc_pay_r <= crc_pay_nxt;
      vd_r <= vd_nxt;
      vdv_r <= vdv_nxt;
      first_r <= first_nxt;
      kind_r <= kind_nxt;
    end
  end

  assign verdict = vd_r;
  assign verdict_valid = vdv_r;

  psc_fifo #(
    .WIDTH($bits(psc_beat_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .reset(reset),
    .in_data(beat),
    .in_valid(beat_valid),
    .in_ready(fifo_in_ready),
    .out_data(pay_beat),
    .out_valid(pay_valid),
    .out_ready(pay_ready)
  );
endmodule : psc_checker

// file: inc/psc_pkg.sv
// Package of constants and types for the private section checker
package psc_pkg;
  localparam int PSC_HDR_BYTES = 8;
  localparam int PSC_LEN_BITS = 12;
  localparam int PSC_TRL_BYTES = 4;
  localparam logic [11:0] PSC_LEN_MIN = 12'h009;
  localparam logic [31:0] PSC_CRC_POLY = 32'h04c11db7;
  localparam logic [31:0] PSC_CRC_INIT = 32'hffffffff;
  localparam logic [31:0] PSC_NO_CRC = 32'hffffffff;
  localparam logic [7:0] PSC_TID_MPE = 8'h0a;
  localparam logic [7:0] PSC_TID_MSG = 8'h0b;
  localparam logic [7:0] PSC_TID_DESC = 8'h0c;
  localparam logic [2:0] PSC_IDX_FLAGS = 3'h1;
  localparam logic [2:0] PSC_IDX_LEN_LO = 3'h2;
  localparam logic [2:0] PSC_IDX_EXT_HI = 3'h3;
  localparam logic [2:0] PSC_IDX_EXT_LO = 3'h4;
  localparam logic [2:0] PSC_IDX_VER = 3'h5;
  localparam logic [2:0] PSC_IDX_SECNUM = 3'h6;
  localparam logic [2:0] PSC_IDX_LAST = 3'h7;
  localparam int PSC_BIT_SYNTAX = 7;
  localparam int PSC_BIT_PRIV = 6;
  localparam int PSC_LEN_HI_MSB = 3;
  localparam int PSC_VER_MSB = 5;
  localparam int PSC_VER_LSB = 1;
  localparam int PSC_BIT_CN = 0;

  typedef enum logic [1:0] {
    PSC_KIND_MPE = 2'b00,
    PSC_KIND_MSG = 2'b01,
    PSC_KIND_DESC = 2'b10,
    PSC_KIND_OTHER = 2'b11
  } psc_kind_t;

  // One payload byte handed to the consumer
  typedef struct packed {
    logic [7:0] data;
    logic first;
    logic last;
    psc_kind_t kind;
  } psc_beat_t;

  // Verdict for one whole section
  typedef struct packed {
    logic [7:0] table_id;
    logic syntax;
    logic [4:0] version;
    logic current_next;
    logic [7:0] section_number;
    logic [7:0] last_section_number;
    logic [11:0] length;
    logic err_priv;
    logic err_trailer;
    logic err_length;
  } psc_verdict_t;
endpackage : psc_pkg

// file: rtl/psc_fifo.sv
// Parameterised valid/ready FIFO used in the payload path
`timescale 1ns/100ps
module psc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  // Pointer wrap relies on a power-of-two depth, so anything else is refused
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("psc_fifo depth must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic push, pop;

  assign in_ready = (wr_r - rd_r) != (AW+1)'(DEPTH);
  assign out_valid = wr_r != rd_r;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_r[AW-1:0]];

  always_comb begin
    wr_nxt = wr_r + (AW+1)'(push);
    rd_nxt = rd_r + (AW+1)'(pop);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
    end
    if (push) begin
      mem[wr_r[AW-1:0]] <= in_data;
    end
  end
endmodule : psc_fifo

// file: verification/psc_sink.sv
// Payload consumer model that accepts promptly or stalls
`timescale 1ns/100ps
module psc_sink (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic slow,
  output logic pay_ready
);
  logic [4:0] cnt_r;
  always_ff @(posedge ref_clk) begin
    cnt_r <= reset ? 5'h0 : cnt_r + 5'h1;
  end
  // Slow mode takes one beat in 32 so the payload FIFO really fills
  assign pay_ready = !slow || cnt_r == 5'h0;
endmodule : psc_sink

// file: verification/psc_checker_properties.sv
// Concurrent checks on the section checker ports
`timescale 1ns/100ps
module psc_props (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] sec_data,
  input wire logic sec_valid,
  input wire logic sec_start,
  input wire logic sec_ready,
  input wire psc_pkg::psc_beat_t pay_beat,
  input wire logic pay_valid,
  input wire logic pay_ready,
  input wire psc_pkg::psc_verdict_t verdict,
  input wire logic verdict_valid
);
  import psc_pkg::*;
  logic tk;
  logic [11:0] cnt_r;
  logic [11:0] len_r;
  logic [7:0] fl_r;
  logic [31:0] sh_r;
  assign tk = sec_valid && sec_ready;
  // Byte index and header fields rebuilt from the wire alone
  always_ff @(posedge ref_clk) begin
    if (reset)
      cnt_r <= 12'h0;
    else if (tk)
      cnt_r <= sec_start ? 12'h1 : cnt_r + 12'h1;
    if (tk && cnt_r == 12'h1)
      {fl_r, len_r[11:8]} <= {sec_data, sec_data[3:0]};
    if (tk && cnt_r == 12'h2)
      len_r[7:0] <= sec_data;
    if (tk)
      sh_r <= {sh_r[23:0], sec_data};
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence s_end;
    tk && !sec_start && cnt_r == (len_r < PSC_LEN_MIN ? 12'h7 : len_r + 12'h2);
  endsequence
  property p_end; s_end |=> verdict_valid; endproperty
  a_end: assert property (p_end) else $error("verdict late");
  property p_cnt;
    verdict_valid |-> cnt_r == (verdict.err_length ? 12'h8 : verdict.length + 12'h3);
  endproperty
  a_cnt: assert property (p_cnt) else $error("verdict early");
  property p_len;
    verdict_valid |-> verdict.length == len_r && verdict.err_length == (len_r < PSC_LEN_MIN);
  endproperty
  a_len: assert property (p_len) else $error("length field");
  property p_priv;
    verdict_valid |-> verdict.syntax == fl_r[7] && verdict.err_priv == (fl_r[7] == fl_r[6]);
  endproperty
  a_priv: assert property (p_priv) else $error("private flag");
  property p_ones;
    verdict_valid && !verdict.syntax && !verdict.err_length |->
      verdict.err_trailer == (sh_r != PSC_NO_CRC);
  endproperty
  a_ones: assert property (p_ones) else $error("all ones trailer");
  property p_pulse; verdict_valid |=> !verdict_valid; endproperty
  a_pulse: assert property (p_pulse) else $error("verdict pulse");
  property p_hdr; cnt_r < 12'h8 |-> sec_ready; endproperty
  a_hdr: assert property (p_hdr) else $error("header refused");
  property p_hold; pay_valid && !pay_ready |=> pay_valid && $stable(pay_beat); endproperty
  a_hold: assert property (p_hold) else $error("beat dropped");
endmodule : psc_props
bind psc_checker psc_props props_u (.ref_clk, .reset, .sec_data, .sec_valid, .sec_start,
  .sec_ready, .pay_beat, .pay_valid, .pay_ready, .verdict, .verdict_valid);

// file: verification/testbench.sv
// Self-checking bench for the private section checker
`timescale 1ns/100ps
module testbench;
  import psc_pkg::*;
  logic ref_clk;
  logic reset;
  logic [7:0] sec_data;
  logic sec_valid;
  logic sec_start;
  logic sec_ready;
  psc_beat_t pay_beat;
  logic pay_valid;
  logic pay_ready;
  psc_verdict_t verdict;
  logic verdict_valid;
  logic slow;
  logic [31:0] rs;
  int fails;
  int samples_checked;
  psc_beat_t exp_q[$];
  psc_verdict_t ev_q[$];
  psc_checker dut_u (.ref_clk, .reset, .sec_data, .sec_valid, .sec_start, .sec_ready,
    .pay_beat, .pay_valid, .pay_ready, .verdict, .verdict_valid);
  psc_sink sink_u (.ref_clk, .reset, .slow, .pay_ready);
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  function automatic logic [7:0] rb();
    rs = {rs[30:0], rs[31] ^ rs[21] ^ rs[1] ^ rs[0]};
    return rs[7:0];
  endfunction : rb
  function automatic logic [31:0] crc(logic [31:0] c, logic [7:0] b);
    for (int i = 7; i >= 0; i--)
      c = {c[30:0], 1'b0} ^ (c[31] ^ b[i] ? PSC_CRC_POLY : 32'h0);
    return c;
  endfunction : crc
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("BAD at %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic finish_test();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  task automatic put(input logic [7:0] b, input logic st);
    sec_data <= b;
    sec_valid <= 1'b1;
    sec_start <= st;
    do
      @(negedge ref_clk);
    while (sec_ready !== 1'b1);
    @(posedge ref_clk);
  endtask : put
  task automatic send(input logic [7:0] tid, input logic syn, prv, bad, input int len);
    logic [7:0] q[$];
    logic [31:0] c;
    logic [1:0] k;
    q = {tid};
    q.push_back({syn, prv, 2'b11, 4'(len >> 8)});
    q.push_back(8'(len));
    repeat (5) q.push_back(rb());
    for (int i = 9; i < len; i++)
      q.push_back(rb());
    c = PSC_CRC_INIT;
    foreach (q[i]) c = crc(c, q[i]);
    c = (syn ? c : PSC_NO_CRC) ^ 32'(bad);
    k = tid > 8'h09 && tid < 8'h0d ? 2'(tid - 8'h0a) : 2'h3;
    for (int i = 8; i < len - 1; i++)
      exp_q.push_back(psc_beat_t'{q[i], i == 8, i == len - 2, psc_kind_t'(k)});
    for (int i = 3; i >= 0 && len > 8; i--)
      q.push_back(c[8 * i +: 8]);
    ev_q.push_back(psc_verdict_t'{tid, syn, q[5][5:1], q[5][0], q[6], q[7], 12'(len), prv == syn, bad,
      len < 9});
    foreach (q[i]) put(q[i], i == 0);
  endtask : send
  always @(negedge ref_clk) begin
    if (pay_valid === 1'b1 && pay_ready === 1'b1)
      chk(pay_beat, exp_q.pop_front());
    if (verdict_valid === 1'b1)
      chk(verdict, ev_q.pop_front());
  end
  initial begin
    rs = 32'h00753c38;
    fails = 0;
    samples_checked = 0;
    reset = 1'b1;
    {sec_data, sec_valid, sec_start, slow} = '0;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    // Odd tests use a CRC; 2,3 corrupt the trailer, 4,5 the flag, 6 is short
    // Table ids double as stream types; all sections together stay under 512 bytes
    for (int t = 0; t < 8; t++) begin
      slow <= t == 7;
      send(8'h0a + 8'(t % 4), t[0], !t[0] ^ (t == 4 || t == 5), t == 2 || t == 3,
        t == 6 ? 5 : 10 + t * 6);
      $display("test %0d done", t);
    end
    sec_valid <= 1'b0;
    sec_start <= 1'b0;
    while (exp_q.size() > 0 || ev_q.size() > 0)
      @(posedge ref_clk);
    finish_test();
  end
  // Roughly fourteen times the slow drain of the longest test
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    finish_test();
  end
endmodule : testbench
